// >>> shared/hsync_timing_pkg.sv
// horizontal blank/sync timing: register map, field layout, bus types
// assumes a 32-bit avalon-mm slave with word addressing in bytes
package hsync_timing_pkg;
  localparam int unsigned ADDR_W = 16;
  // line total / active register sits beside the two positions registers
  localparam logic [ADDR_W-1:0] OFS_LINE_TOTALS          = 16'h8330;
  localparam logic [ADDR_W-1:0] OFS_HORIZONTAL_BLANK_POS = 16'h8334;
  localparam logic [ADDR_W-1:0] OFS_HORIZONTAL_SYNC_POS  = 16'h8338;
  localparam logic [ADDR_W-1:0] OFS_VLINE_STATUS         = 16'h833c;
  // field positions: high field 26:19, low field 10:3
  localparam int unsigned HI_MSB = 26;
  localparam int unsigned HI_LSB = 19;
  localparam int unsigned LO_MSB = 10;
  localparam int unsigned LO_LSB = 3;
  localparam int unsigned CNT_W  = 8;
  localparam int unsigned VCNT_W = 11;
  // writable bits: 26:16 and 10:0, reserved read as zero
  localparam logic [31:0] WRITE_MASK  = 32'h07ff_07ff;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [3:0]        byteenable;
    logic [31:0]       writedata;
  } avmm_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avmm_rsp_type;

  typedef struct packed {
    logic             hblank;
    logic             hsync;
    logic             active;
    logic             line_step;
    logic [CNT_W-1:0] hcount;
  } video_timing_type;
endpackage

// >>> rtl/hsync_timing.sv
// horizontal blank/sync generator with avalon-mm register slave
// assumes one character clock per clk_sys_i cycle, synchronous reset
//
// Overview of operation
// - blank ends at counter match, field 26:19
// - blank end low bits 18:16 ignored
// - blank starts at counter match, field 10:3
// - blank start bits 2:0 don't care
// - sync deasserts at sync end match
// - sync end bits 18:16 ignored
// - sync asserts at sync start match
// - sync start bits 2:0 ignored
// - vertical counter steps on sync rising transition
// - line length is total field plus one
// - active width is active field plus one
`timescale 1ns/1ps
module hsync_timing
  import hsync_timing_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire logic             srst_i,
  input  wire avmm_req_type     avmm_req_i,
  output avmm_rsp_type          avmm_rsp_o,
  output video_timing_type      timing_o,
  output logic [VCNT_W-1:0]     vline_o
);

  typedef struct packed {
    logic [31:0]       line_totals;
    logic [31:0]       blank_pos;
    logic [31:0]       sync_pos;
    logic [CNT_W-1:0]  hcount;
    logic [VCNT_W-1:0] vcount;
    logic              hblank;
    logic              hsync;
    logic              line_step;
    logic              rd_ack;
    logic [31:0]       readdata;
  } state_type;

  state_type st;
  state_type next_st;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & WRITE_MASK;
    merge = (old & ~m) | (wd & m);
  endfunction

  logic [CNT_W-1:0] total_cnt;
  logic [CNT_W-1:0] active_cnt;
  logic [CNT_W-1:0] blank_end;
  logic [CNT_W-1:0] blank_begin;
  logic [CNT_W-1:0] sync_end;
  logic [CNT_W-1:0] sync_begin;

  always_comb begin
    total_cnt   = st.line_totals[HI_MSB:HI_LSB];
    active_cnt  = st.line_totals[LO_MSB:LO_LSB];
    blank_end   = st.blank_pos[HI_MSB:HI_LSB];
    blank_begin = st.blank_pos[LO_MSB:LO_LSB];
    sync_end    = st.sync_pos[HI_MSB:HI_LSB];
    sync_begin  = st.sync_pos[LO_MSB:LO_LSB];
  end

  always_comb begin
    next_st = st;
    next_st.line_step = 1'b0;
    next_st.rd_ack    = 1'b0;
    if (st.hcount == total_cnt) begin
      next_st.hcount = '0;
    end else begin
      next_st.hcount = st.hcount + 1'b1;
    end
    if (st.hcount == blank_begin) begin
      next_st.hblank = 1'b1;
    end
    if (st.hcount == blank_end) begin
      next_st.hblank = 1'b0;
    end
    if (st.hcount == sync_begin) begin
      next_st.hsync = 1'b1;
    end
    if (st.hcount == sync_end) begin
      next_st.hsync = 1'b0;
    end
    if (next_st.hsync && !st.hsync) begin
      next_st.line_step = 1'b1;
      next_st.vcount    = st.vcount + 1'b1;
    end
    // register slave
    if (avmm_req_i.write) begin
      case (avmm_req_i.address)
        OFS_LINE_TOTALS: begin
          next_st.line_totals = merge(st.line_totals, avmm_req_i.writedata, avmm_req_i.byteenable);
        end
        OFS_HORIZONTAL_BLANK_POS: begin
          next_st.blank_pos = merge(st.blank_pos, avmm_req_i.writedata, avmm_req_i.byteenable);
        end
        OFS_HORIZONTAL_SYNC_POS: begin
          next_st.sync_pos = merge(st.sync_pos, avmm_req_i.writedata, avmm_req_i.byteenable);
        end
        OFS_VLINE_STATUS: begin
          next_st.vcount = '0;
        end
        default: begin
        end
      endcase
    end
    if (avmm_req_i.read && !st.rd_ack) begin
      next_st.rd_ack = 1'b1;
      case (avmm_req_i.address)
        OFS_LINE_TOTALS:          next_st.readdata = st.line_totals;
        OFS_HORIZONTAL_BLANK_POS: next_st.readdata = st.blank_pos;
        OFS_HORIZONTAL_SYNC_POS:  next_st.readdata = st.sync_pos;
        OFS_VLINE_STATUS:         next_st.readdata = {5'h00, st.vcount, 8'h00, st.hcount};
        default:                  next_st.readdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st.line_totals <= RESET_VALUE;
      st.blank_pos   <= RESET_VALUE;
      st.sync_pos    <= RESET_VALUE;
      st.hcount      <= '0;
      st.vcount      <= '0;
      st.hblank      <= 1'b0;
      st.hsync       <= 1'b0;
      st.line_step   <= 1'b0;
      st.rd_ack      <= 1'b0;
      st.readdata    <= READ_ZERO;
    end else begin
      st <= next_st;
    end
  end

  // writes complete at once, reads one cycle later
  assign avmm_rsp_o.waitrequest = avmm_req_i.read && !st.rd_ack;
  assign avmm_rsp_o.readdata    = st.readdata;
  assign timing_o.hblank        = st.hblank;
  assign timing_o.hsync         = st.hsync;
  assign timing_o.active        = (st.hcount <= active_cnt);
  assign timing_o.line_step     = st.line_step;
  assign timing_o.hcount        = st.hcount;
  assign vline_o                = st.vcount;

endmodule

// >>> tb/hsync_timing_sva.sv
// checker: port-level bus and line timing relations of hsync_timing
// assumes full-word writes; shadows the position registers from the bus
`timescale 1ns/1ps
module hsync_timing_sva
  import hsync_timing_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              srst_i,
  input wire avmm_req_type      avmm_req_i,
  input wire avmm_rsp_type      avmm_rsp_o,
  input wire video_timing_type  timing_o,
  input wire logic [VCNT_W-1:0] vline_o
);
  logic [31:0] sh [4];
  wire  [7:0]  h = timing_o.hcount;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  always_ff @(posedge clk_sys_i) begin
    if (srst_i)
      sh <= '{default: '0};
    else if (avmm_req_i.write && avmm_req_i.address[15:4] == 12'h833)
      sh[avmm_req_i.address[3:2]] <= avmm_req_i.writedata;
  end
  sequence rd_ans;
    avmm_rsp_o.waitrequest ##1 !avmm_rsp_o.waitrequest;
  endsequence
  rd_wait_a: assert property ($rose(avmm_req_i.read) |-> rd_ans)
    else $error("read answer late");
  line_wrap_a: assert property (h == sh[0][26:19] |=> h == 8'h00)
    else $error("no wrap");
  hcount_step_a: assert property (h != sh[0][26:19] |=> h == $past(h) + 8'h01)
    else $error("bad count");
  sync_on_a: assert property (h == sh[2][10:3] && h != sh[2][26:19] |=> timing_o.hsync)
    else $error("sync not raised");
  sync_off_a: assert property (h == sh[2][26:19] |=> !timing_o.hsync)
    else $error("sync not dropped");
  blank_on_a: assert property (h == sh[1][10:3] && h != sh[1][26:19] |=> timing_o.hblank)
    else $error("blank not raised");
  blank_off_a: assert property (h == sh[1][26:19] |=> !timing_o.hblank)
    else $error("blank not dropped");
  line_step_a: assert property (timing_o.line_step == $rose(timing_o.hsync))
    else $error("bad line step");
  vline_step_a: assert property ($rose(timing_o.hsync) |-> vline_o == $past(vline_o) + 11'h001)
    else $error("vline not stepped");
endmodule
bind hsync_timing hsync_timing_sva u_sva (.clk_sys_i, .srst_i, .avmm_req_i, .avmm_rsp_o, .timing_o, .vline_o);

// >>> tb/crt_monitor.sv
// partner: crt monitor measuring sync width and line period
// assumes active-high hsync level
`timescale 1ns/1ps
module crt_monitor
  import hsync_timing_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire video_timing_type timing_i,
  output logic [7:0]            sync_w_o,
  output logic [7:0]            period_o
);
  logic [7:0] s    = 8'h00;
  logic [7:0] p    = 8'h00;
  logic       hs_d = 1'b0;
  always @(posedge clk_sys_i) begin
    s    <= timing_i.hsync ? s + 8'h01 : 8'h00;
    p    <= (timing_i.hsync && !hs_d) ? 8'h01 : p + 8'h01;
    hs_d <= timing_i.hsync;
    if (hs_d && !timing_i.hsync)
      sync_w_o <= s;
    if (timing_i.hsync && !hs_d)
      period_o <= p;
  end
endmodule

// >>> tb/tb.sv
// testbench: register access and line timing of hsync_timing
// assumes crt_monitor partner and the bound checker
`timescale 1ns/1ps
module tb;
  import hsync_timing_pkg::*;
  logic              clk_sys_i    = 1'b0;
  logic              srst_i       = 1'b1;
  avmm_req_type      req          = '0;
  avmm_rsp_type      rsp;
  video_timing_type  tim;
  logic [VCNT_W-1:0] vline;
  logic [7:0]        sync_w;
  logic [7:0]        period;
  logic [31:0]       q;
  int                fail_count   = 0;
  int                total_checks = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  hsync_timing u_hsync_timing (.clk_sys_i, .srst_i, .avmm_req_i(req), .avmm_rsp_o(rsp), .timing_o(tim), .vline_o(vline));
  crt_monitor u_crt_monitor (.clk_sys_i, .timing_i(tim), .sync_w_o(sync_w), .period_o(period));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic rd, input logic [15:0] a, input logic [31:0] d);
    req <= '{a, rd, !rd, 4'hf, d};
    @(posedge clk_sys_i);
    while (rsp.waitrequest === 1'b1)
      @(posedge clk_sys_i);
    q = rsp.readdata;
    req <= '0;
    @(posedge clk_sys_i);
  endtask
  task automatic t_regs;
    bus(1'b1, OFS_HORIZONTAL_SYNC_POS, '0);
    chk("sync reset", RESET_VALUE, q);
    bus(1'b0, 16'h8340, 32'h0000_ffff);
    bus(1'b1, 16'h8340, '0);
    chk("unmapped", READ_ZERO, q);
  endtask
  task automatic t_line;
    logic [VCNT_W-1:0] v;
    bus(1'b0, OFS_HORIZONTAL_BLANK_POS, 32'h008f_0047);
    bus(1'b0, OFS_HORIZONTAL_SYNC_POS, 32'h0077_0057);
    bus(1'b0, OFS_LINE_TOTALS, 32'h009f_004f);
    bus(1'b1, OFS_HORIZONTAL_SYNC_POS, '0);
    chk("sync readback", 32'h0077_0057 & WRITE_MASK, q);
    repeat (45) @(posedge clk_sys_i);
    v = vline;
    chk("sync width", 14 - 10, sync_w);
    chk("line period", 19 + 1, period);
    repeat (60) @(posedge clk_sys_i);
    chk("line steps", v + 3, vline);
  endtask
  task automatic t_shape;
    do @(posedge clk_sys_i); while (tim.hcount !== 8'h03);
    chk("blank off", 1'b0, tim.hblank);
    chk("active on", 1'b1, tim.active);
    do @(posedge clk_sys_i); while (tim.hcount !== 8'h0b);
    chk("line step", 1'b1, tim.line_step);
    chk("sync on", 1'b1, tim.hsync);
    @(posedge clk_sys_i);
    chk("step pulse", 1'b0, tim.line_step);
    chk("blank on", 1'b1, tim.hblank);
    chk("active off", 1'b0, tim.active);
  endtask
  task automatic t_status;
    do @(posedge clk_sys_i); while (tim.hcount !== 8'h0f);
    bus(1'b0, OFS_VLINE_STATUS, '0);
    bus(1'b1, OFS_VLINE_STATUS, '0);
    chk("status word", 32'h0000_0012, q);
    chk("vline cleared", '0, vline);
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_regs();
    t_line();
    t_shape();
    t_status();
    end_of_test();
  end
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    fail_count++;
    end_of_test();
  end
endmodule
